// ===== fcc_top.v
// fast capture control: host byte port, control word, detection,
// sample memory, arming and trigger address latch
// assumes host pins synchronous to clk; strobes are one-cycle pulses
//
// Summary of operation
// - full rate forces hold-select low.
// - sample mode forces hold-select low; last sample kept.
// - positive peak: low when new above stored, high when below.
// - pit: low when new below stored, high when above or equal.
// - first tick of each bucket forces hold-select low.
// - memory stores samples in write mode, host reads otherwise.
// - host bus: 8-bit data, port select, high and low strobes.
// - port select low is control word, high is data port.
// - data port takes bytes or words, high byte first.
// - bit 0 runs clocks and writes; clear stops, memory readable.
// - bit 1 arms sweep or video trigger; clear blocks triggers.
// - bit 6 low permits host loads of the address counter.
// - bit 7 low permits host loads of the post-trigger counter.
// - bit 8 low enables the video trigger.
// - bit 9 low enables read clock for loads and post-increment.
// - bit 10 low routes memory to host for reading.
// - bit 11 low allows reading the trigger address latch.
// - rate generator gives 1 to 256 samples per bucket.
// - trigger latches address, starts post count until terminal.
// - after a trigger, ignore more until arm low then high.
// - comparator flags above, below, none when equal.
// - detection latch loads only while hold-select low.
// - peak keeps max, pit min, sample the last per bucket.
`timescale 1ns/1ps
`include "fcc_regs.vh"
module fcc_top #(
	parameter AW = 15,
	parameter DW = 8
) (
	input wire clk,
	input wire rst_b,
	input wire [7:0] host_data_in,
	output reg [7:0] host_data_out_q,
	output reg host_data_oe_q,
	input wire port_select,
	input wire high_byte_strobe,
	input wire low_byte_strobe,
	input wire [DW-1:0] adc_sample,
	input wire full_rate_select,
	input wire [7:0] rate_divisor,
	input wire sweep_trigger_line,
	input wire video_trigger_pulse,
	output reg [15:0] control_word_q,
	output reg triggered_q,
	output reg post_stop_q,
	output reg hold_select_q,
	output reg new_above_q,
	output reg new_below_q
);
	localparam ST_IDLE = 3'b001;
	localparam ST_ARMED = 3'b010;
	localparam ST_TRIG = 3'b100;
	localparam DEPTH = 1 << AW;

	// next address, wrapping round the circular memory
	function [AW-1:0] addr_next;
		input [AW-1:0] a;
		begin
			addr_next = a + {{(AW-1){1'b0}}, 1'b1};
		end
	endfunction

	// an active-low control bit reads as an enable
	function ctl_low;
		input [15:0] cw;
		input integer pos;
		begin
			ctl_low = !cw[pos];
		end
	endfunction

	// byte of the trigger address for the host: high or low half
	function [7:0] taddr_byte;
		input hi;
		input [AW-1:0] a;
		begin
			if (hi) begin
				taddr_byte = {{(16-AW){1'b0}}, a[AW-1:8]};
			end else begin
				taddr_byte = a[7:0];
			end
		end
	endfunction

	reg [DW-1:0] mem [0:DEPTH-1];
	reg [DW-1:0] det_q;
	reg [AW-1:0] addr_q;
	reg [AW-1:0] taddr_q;
	reg [15:0] post_q;
	reg [7:0] rate_cnt_q;
	reg [7:0] hi_byte_q;
	reg [2:0] st_q;
	reg [2:0] st_d;
	reg arm_prev_q;
	reg post_run_q;
	wire hold_select;
	wire new_above;
	wire new_below;
	wire write_mode = control_word_q[`FCC_BIT_WRITE];
	wire arm = control_word_q[`FCC_BIT_ARM];
	wire load_addr_ok =
		ctl_low(control_word_q, `FCC_BIT_LOAD_ADDR_N);
	wire load_post_ok =
		ctl_low(control_word_q, `FCC_BIT_LOAD_POST_N);
	wire vtrig_ok =
		ctl_low(control_word_q, `FCC_BIT_VTRIG_EN_N);
	wire rclk_ok =
		ctl_low(control_word_q, `FCC_BIT_READ_CLK_N);
	wire rmem_ok =
		ctl_low(control_word_q, `FCC_BIT_READ_MEM_N);
	wire rtaddr_ok =
		ctl_low(control_word_q, `FCC_BIT_READ_TADDR_N);
	wire peak_pol_n = control_word_q[`FCC_BIT_PEAK_POL_N];
	// sample mode, active low: last sample of each bucket kept
	wire sample_mode_n = control_word_q[`FCC_BIT_SAMPLE_N];
	wire strobe = high_byte_strobe | low_byte_strobe;
	wire sec_wr = port_select && strobe && !write_mode;
	wire word_done = port_select && low_byte_strobe && !write_mode;
	wire [15:0] host_word = {hi_byte_q, host_data_in};
	// bucket tick: one enable per rate_divisor+1 samples
	wire tick = (rate_cnt_q == `FCC_RATE_TICK);
	wire first_tick = tick && !full_rate_select;
	wire sample_en = write_mode;
	wire addr_en = write_mode && (full_rate_select || tick) &&
		!post_stop_q;
	wire trig_src = sweep_trigger_line | (vtrig_ok & video_trigger_pulse);
	wire mem_rd = port_select && low_byte_strobe && !write_mode &&
		rmem_ok;
	wire taddr_rd = port_select && strobe && !write_mode &&
		rtaddr_ok;
	// one-cycle pulse on the edge that accepts a trigger
	wire trig_take = (st_q == ST_ARMED) && (st_d == ST_TRIG);

	fcc_hold_sel #(
		.W(DW)
	) u_hold (
		.new_sample(adc_sample),
		.stored_sample(det_q),
		.full_rate_select(full_rate_select),
		.bucket_first_tick(first_tick),
		.sample_mode_n(sample_mode_n),
		.peak_polarity_n(peak_pol_n),
		.hold_select(hold_select),
		.new_above(new_above),
		.new_below(new_below)
	);

	// arm state: accept one trigger per arm rising edge
	always @* begin
		st_d = st_q;
		case (st_q)
		ST_IDLE: begin
			if (arm && !arm_prev_q) begin
				st_d = ST_ARMED;
			end
		end
		ST_ARMED: begin
			if (!arm) begin
				st_d = ST_IDLE;
			end else if (trig_src && write_mode) begin
				st_d = ST_TRIG;
			end
		end
		ST_TRIG: begin
			if (!arm) begin
				st_d = ST_IDLE;
			end
		end
		default: begin
			st_d = ST_IDLE;
		end
		endcase
	end

	// control word and high-byte holding register
	always @(posedge clk) begin
		if (!rst_b) begin
			control_word_q <= `FCC_CW_RESET;
			hi_byte_q <= 8'h00;
		end else begin
			if (!port_select && high_byte_strobe) begin
				hi_byte_q <= host_data_in;
			end
			if (sec_wr && high_byte_strobe) begin
				hi_byte_q <= host_data_in;
			end
			if (!port_select && low_byte_strobe) begin
				control_word_q <= host_word;
			end
		end
	end

	// arm state and trigger flag; flag stays up until disarmed
	always @(posedge clk) begin
		if (!rst_b) begin
			st_q <= ST_IDLE;
			arm_prev_q <= 1'b0;
			triggered_q <= 1'b0;
		end else begin
			st_q <= st_d;
			arm_prev_q <= arm;
			triggered_q <= (st_d == ST_TRIG);
		end
	end

	// rate generator and detection latch
	always @(posedge clk) begin
		if (!rst_b) begin
			rate_cnt_q <= `FCC_RATE_RESET;
			det_q <= {DW{1'b0}};
			hold_select_q <= 1'b0;
			new_above_q <= 1'b0;
			new_below_q <= 1'b0;
		end else begin
			hold_select_q <= hold_select;
			new_above_q <= new_above;
			new_below_q <= new_below;
			if (sample_en) begin
				if (tick) begin
					rate_cnt_q <= rate_divisor;
				end else begin
					rate_cnt_q <= rate_cnt_q - 8'h01;
				end
			end
			if (sample_en && !hold_select) begin
				det_q <= adc_sample;
			end
		end
	end

	// sample memory: written only in write mode, never reset
	always @(posedge clk) begin
		if (addr_en) begin
			mem[addr_q] <= det_q;
		end
	end

	// circular address counter and trigger address latch
	// later assignments win: a host load over the write count,
	// a read step over a load (both at once is host contention)
	always @(posedge clk) begin
		if (!rst_b) begin
			addr_q <= {AW{1'b0}};
			taddr_q <= {AW{1'b0}};
		end else begin
			if (addr_en) begin
				addr_q <= addr_next(addr_q);
			end
			if (trig_take) begin
				taddr_q <= addr_q;
			end
			if (word_done && rclk_ok && load_addr_ok) begin
				addr_q <= host_word[AW-1:0];
			end
			if (mem_rd && rclk_ok && !post_stop_q) begin
				addr_q <= addr_next(addr_q);
			end
		end
	end

	// post-trigger counter: holds at terminal until the host reloads
	// it; a reload to terminal count keeps addressing stopped
	always @(posedge clk) begin
		if (!rst_b) begin
			post_q <= `FCC_POST_RESET;
			post_run_q <= 1'b0;
			post_stop_q <= 1'b0;
		end else begin
			if (trig_take) begin
				post_run_q <= 1'b1;
			end
			if (post_run_q && addr_en) begin
				if (post_q == `FCC_POST_TERMINAL) begin
					post_stop_q <= 1'b1;
					post_run_q <= 1'b0;
				end else begin
					post_q <= post_q + 16'h0001;
				end
			end
			if (word_done && rclk_ok && load_post_ok) begin
				post_q <= host_word;
				post_stop_q <= (host_word == `FCC_POST_TERMINAL);
			end
		end
	end

	// host read port: drives for one cycle after a read strobe;
	// a memory read takes the port ahead of the trigger address
	always @(posedge clk) begin
		if (!rst_b) begin
			host_data_out_q <= 8'h00;
			host_data_oe_q <= 1'b0;
		end else begin
			host_data_oe_q <= 1'b0;
			if (mem_rd) begin
				host_data_out_q <= mem[addr_q];
				host_data_oe_q <= 1'b1;
			end else if (taddr_rd) begin
				host_data_oe_q <= 1'b1;
				host_data_out_q <= taddr_byte(high_byte_strobe, taddr_q);
			end
		end
	end
endmodule // fcc_top

// ===== fcc_regs.vh
// constants for the fast capture control block
// assumes inclusion by bare name from design files
`ifndef FCC_REGS_VH
`define FCC_REGS_VH
`define FCC_CW_RESET 16'hffc0
`define FCC_BIT_WRITE 0
`define FCC_BIT_ARM 1
`define FCC_BIT_LOAD_ADDR_N 6
`define FCC_BIT_LOAD_POST_N 7
`define FCC_BIT_VTRIG_EN_N 8
`define FCC_BIT_READ_CLK_N 9
`define FCC_BIT_READ_MEM_N 10
`define FCC_BIT_READ_TADDR_N 11
`define FCC_BIT_SAMPLE_N 2
`define FCC_BIT_PEAK_POL_N 15
`define FCC_POST_TERMINAL 16'hffff
`define FCC_RATE_RESET 8'h00
`define FCC_RATE_TICK 8'h00
`define FCC_POST_RESET 16'h0000
`endif

// ===== fcc_hold_sel.v
// hold-select decode and detection comparator
// assumes stored and new samples are stable within the cycle
`timescale 1ns/1ps
module fcc_hold_sel #(
	parameter W = 8
) (
	input wire [W-1:0] new_sample,
	input wire [W-1:0] stored_sample,
	input wire full_rate_select,
	input wire bucket_first_tick,
	input wire sample_mode_n,
	input wire peak_polarity_n,
	output reg hold_select,
	output reg new_above,
	output reg new_below
);
	always @* begin
		new_above = (new_sample > stored_sample);
		new_below = (new_sample < stored_sample);
		if (full_rate_select) begin
			hold_select = 1'b0;
		end else if (!sample_mode_n) begin
			hold_select = 1'b0;
		end else if (bucket_first_tick) begin
			hold_select = 1'b0;
		end else if (!peak_polarity_n) begin
			hold_select = !new_above;
		end else begin
			hold_select = !new_below;
		end
	end
endmodule // fcc_hold_sel

// ===== fcc_chk.sv
// assertions on the fast capture control ports
// assumes bind onto fcc_top; one clock, sync active-low reset
`timescale 1ns/1ps
module fcc_chk (
	input wire clk,
	input wire rst_b,
	input wire [7:0] host_data_in,
	input wire host_data_oe_q,
	input wire port_select,
	input wire high_byte_strobe,
	input wire low_byte_strobe,
	input wire full_rate_select,
	input wire [15:0] control_word_q,
	input wire triggered_q,
	input wire hold_select_q,
	input wire new_above_q,
	input wire new_below_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_hi; !port_select && high_byte_strobe; endsequence
	sequence s_lo; !port_select && low_byte_strobe; endsequence
	sequence s_rd; port_select && (high_byte_strobe || low_byte_strobe);
	endsequence
	AST_CW_PAIR: assert property (s_hi ##1 s_lo |=>
		control_word_q == {$past(host_data_in, 2), $past(host_data_in)})
		else $error("control word pair wrong");
	AST_FULL_RATE: assert property (full_rate_select |=> !hold_select_q)
		else $error("hold high at full rate");
	AST_SAMPLE: assert property (!control_word_q[2] |=> !hold_select_q)
		else $error("hold high in sample mode");
	AST_CMP_EXCL: assert property (!(new_above_q && new_below_q))
		else $error("above and below both set");
	AST_RD_SEL: assert property (host_data_oe_q |-> $past(port_select)
		&& ($past(high_byte_strobe) || $past(low_byte_strobe)))
		else $error("drive without data port read");
	AST_RD_WR: assert property (s_rd ##0 control_word_q[0] |=>
		!host_data_oe_q) else $error("read in write mode");
	AST_RD_EN: assert property (host_data_oe_q |->
		!$past(control_word_q[10]) || !$past(control_word_q[11]))
		else $error("read while reads blocked");
	AST_TRIG_ARM: assert property ($rose(triggered_q) |->
		$past(control_word_q[1]) && $past(control_word_q[0]))
		else $error("trigger while disarmed");
	AST_TRIG_HOLD: assert property (triggered_q &&
		control_word_q[1:0] == 2'b11 |=> triggered_q)
		else $error("trigger state lost while armed");
endmodule // fcc_chk

// ===== fcc_host_model.sv
// host controller model: byte-strobed access to the capture block
// assumes tasks are entered at a falling edge of clk
`timescale 1ns/1ps
module fcc_host_model (
	input wire clk,
	input wire [7:0] host_data_out_q,
	input wire host_data_oe_q,
	output logic [7:0] host_data_in,
	output logic port_select,
	output logic high_byte_strobe,
	output logic low_byte_strobe
);
	initial begin
		host_data_in = 8'h00;
		port_select = 1'b0;
		high_byte_strobe = 1'b0;
		low_byte_strobe = 1'b0;
	end
	// caller sets the control word before any data access
	task automatic word(input logic ps, input logic [15:0] w);
		@(negedge clk);
		port_select = ps;
		host_data_in = w[15:8];
		high_byte_strobe = 1'b1;
		@(negedge clk);
		high_byte_strobe = 1'b0;
		low_byte_strobe = 1'b1;
		host_data_in = w[7:0];
		@(negedge clk);
		low_byte_strobe = 1'b0;
		host_data_in = ~w[7:0];
	endtask
	task automatic rd(output logic [7:0] d, output logic e);
		@(negedge clk);
		port_select = 1'b1;
		low_byte_strobe = 1'b1;
		@(negedge clk);
		d = host_data_out_q;
		e = host_data_oe_q;
		low_byte_strobe = 1'b0;
	endtask
endmodule // fcc_host_model

// ===== tb.sv
// testbench for fast capture control: host port, arming, detection
// assumes fcc_top, fcc_chk and fcc_host_model compiled before it
`timescale 1ns/1ps
module tb;
	logic clk = 0;
	logic rst_b = 0;
	logic fr = 0;
	logic sw = 0;
	logic [7:0] adc = 8'h00;
	logic [7:0] d;
	logic oe;
	logic [7:0] d0;
	wire [7:0] din, dout;
	wire ps, hs, ls, doe, trig, pstop;
	wire [15:0] cw;
	int n_checks = 0;
	int n_mismatch = 0;
	int cyc = 0;
	initial forever #4 clk = ~clk;
	always @(negedge clk) adc <= adc + 8'h35;
	fcc_host_model fcc_host_model_inst (.clk(clk), .host_data_out_q(dout),
		.host_data_oe_q(doe), .host_data_in(din), .port_select(ps),
		.high_byte_strobe(hs), .low_byte_strobe(ls));
	fcc_top fcc_top_inst (.clk(clk), .rst_b(rst_b), .host_data_in(din),
		.host_data_out_q(dout), .host_data_oe_q(doe), .port_select(ps),
		.high_byte_strobe(hs), .low_byte_strobe(ls), .adc_sample(adc),
		.full_rate_select(fr), .rate_divisor(8'h03),
		.sweep_trigger_line(sw), .video_trigger_pulse(1'b0),
		.control_word_q(cw), .triggered_q(trig), .post_stop_q(pstop),
		.hold_select_q(), .new_above_q(), .new_below_q());
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			close_out();
		end
	end
	initial begin
		repeat (4) @(negedge clk);
		rst_b = 1;
		chk("cw", 16'hffc0, cw);
		fcc_host_model_inst.word(0, 16'hfd44);
		chk("cw", 16'hfd44, cw);
		fcc_host_model_inst.word(1, 16'hfffa);
		fcc_host_model_inst.word(0, 16'hffc5);
		fr = 1;
		sw = 1;
		repeat (3) @(negedge clk);
		chk("trig", 0, trig);
		fcc_host_model_inst.rd(d, oe);
		chk("oe", 0, oe);
		sw = 0;
		fr = 0;
		fcc_host_model_inst.word(0, 16'hffc7);
		sw = 1;
		repeat (20) if (!trig) @(negedge clk);
		chk("trig", 1, trig);
		sw = 0;
		repeat (200) if (!pstop) @(negedge clk);
		chk("pstop", 1, pstop);
		fcc_host_model_inst.word(0, 16'hffc3);
		repeat (4) @(negedge clk);
		chk("trig", 1, trig);
		fcc_host_model_inst.word(0, 16'hf9c4);
		fcc_host_model_inst.rd(d, oe);
		chk("oe", 1, oe);
		fcc_host_model_inst.word(0, 16'hf5c4);
		fcc_host_model_inst.rd(d, oe);
		chk("oe", 1, oe);
		fcc_host_model_inst.word(0, 16'hfdc4);
		fcc_host_model_inst.rd(d, oe);
		chk("oe", 0, oe);
		// full-rate phase stored consecutive samples at addresses 1, 2
		fcc_host_model_inst.word(0, 16'hfd04);
		fcc_host_model_inst.word(1, 16'h0001);
		fcc_host_model_inst.word(0, 16'hf9c4);
		fcc_host_model_inst.rd(d0, oe);
		fcc_host_model_inst.rd(d, oe);
		chk("mem step", {8'h00, d0 + 8'h35}, {8'h00, d});
		close_out();
	end
endmodule // tb
bind fcc_top fcc_chk fcc_chk_inst (.*);
